// file: logic/system_clock_reset_sequencer.sv
// clock gating, reset sequencing, watchdog and reset cause logic
//
// Notes on behaviour
// - user mode bus clock runs at half the oscillator rate.
// - power-on or low voltage holds clocks inactive, pin low for 4096 cycles.
// - stop exit counts from the fast clock; clocks off until 4096 or 2048.
// - wait mode stops cpu clock, peripheral clock keeps running.
// - every reset asserts internal reset and selects the reset vector.
// - internal resets clear the stabilisation counter; the pin reset does not.
// - each reset sets its own cause bit.
// - pin must stay low 67 cycles, or 4163 after power-on/low voltage.
// - internal resets drive the pin 32 cycles, then hold reset 32 more.
// - power-on drives pin for 4096 count, releases cpu 64 cycles later.
// - power-on sets the power-on cause and clears the others.
// - watchdog overflow resets, sets its cause, and is synchronised first.
// - watchdog service write clears watchdog and counter stages 12 to 5.
// - prescaler tick comes at least every 4096 minus 16 cycles.
// - test voltage on pins disables the watchdog combinationally.
// - illegal opcode resets; stop with stop disabled counts as illegal.
// - only an opcode fetch from unmapped space resets.
// - low voltage sets its cause, pin low 4096 cycles, cpu free 64 later.
// - single-ended zero longer than 2.5 us is a bus reset.
// - usb reset off when usb disabled; option turns it into an irq.
// - usb enable, usb reset disable, pull-up and sticky bits cleared only by power-on or low voltage.
// - twelve stage counter on falling edge; thirteenth stage wraps and ticks.
// - short stop recovery bit selects 2048, otherwise 4096.
// - bus clock is one quarter of the doubled oscillator clock.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "clk_rst_seq_cfg.svh"

module system_clock_reset_sequencer
    import clk_rst_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic low_voltage_detector,
    input wire logic bad_opcode,
    input wire logic stop_instr,
    input wire logic wait_instr,
    input wire logic wake_event,
    input wire logic unmapped_access,
    input wire logic opcode_fetch,
    input wire logic usb_dp,
    input wire logic usb_dm,
    input wire logic monitor_mode,
    input wire logic break_state,
    input wire logic reset_pin_test_high_voltage,
    input wire logic irq_pin_test_high_voltage,
    output logic internal_reset,
    output logic cpu_clock_on,
    output logic periph_clock_on,
    output logic internal_bus_clock,
    output logic [15:0] reset_vector,
    output logic ext_irq_request,
    output logic usb_module_on,
    output logic usb_pullup_on,
    output logic port_a_bit7_direction
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    seq_e state_r;
    seq_e state_nxt;
    logic [11:0] cnt_r;
    logic cnt_clr_r;
    logic svc_r;
    logic [7:0] ctrl_r;
    logic [7:0] cause_r;
    logic pin_sync1_r;
    logic pin_sync2_r;
    logic [12:0] pin_low_r;
    logic por_lvi_seq_r;
    logic [5:0] wd_cnt_r;
    logic wd_ovf_r;
    logic wd_sync1_r;
    logic wd_sync2_r;
    logic [9:0] se0_cnt_r;
    logic usb_evt_r;
    logic [1:0] div_r;
    logic wd_disable;
    logic presc_tick;
    logic bad_instruction_flag_evt;
    logic bad_fetch_address_flag_evt;
    logic usb_rst_evt;
    logic int_rst_evt;
    logic lvi_start;
    logic [7:0] new_cause;
    logic apb_wr;
    logic apb_rd;
    logic in_reset;
    logic [11:0] stop_end;

    ////////////////////////////////////////////////////////////////////////////
    // event decode

    assign bad_instruction_flag_evt = bad_opcode | (stop_instr & ~ctrl_r[`CTRL_STOP_EN]);
    assign bad_fetch_address_flag_evt = unmapped_access & opcode_fetch;
    assign usb_rst_evt = usb_evt_r & ctrl_r[`CTRL_USB_ON] & ~ctrl_r[`CTRL_USB_RST_DIS]
                         & ~ctrl_r[`CTRL_USB_IRQ_SEL];
    // combinational watchdog disable, no state so noise cannot latch it
    assign wd_disable = (monitor_mode & (reset_pin_test_high_voltage | irq_pin_test_high_voltage))
                        | (break_state & reset_pin_test_high_voltage);
    assign in_reset = (state_r == ST_POR) | (state_r == ST_DRIVE) | (state_r == ST_HOLD)
                      | (state_r == ST_EXT);
    assign lvi_start = low_voltage_detector & (state_r != ST_POR);
    // internal and pin reset sources are only taken outside the reset states; a low voltage wins in every state but ST_POR
    assign int_rst_evt = ~in_reset & (wd_sync2_r | bad_instruction_flag_evt | bad_fetch_address_flag_evt | usb_rst_evt);
    // thirteenth stage: wrap of the twelve counting stages
    assign presc_tick = (cnt_r == `CNT_FULL);
    assign stop_end = ctrl_r[`CTRL_SHORT_STOP] ? `CNT_HALF : `CNT_FULL;

    ////////////////////////////////////////////////////////////////////////////
    // stabilisation counter on the falling edge

    // falling edge count; half a cycle ahead of the sequencer's sampling
    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 12'h000;
        end else if (cnt_clr_r) begin
            // cleared on internal reset and stop entry
            cnt_r <= 12'h000;
        end else if (svc_r) begin
            // service clears stages 12 to 5
            cnt_r <= cnt_r & `CNT_SVC_MASK;
        end else begin
            cnt_r <= cnt_r + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset pin synchroniser and low time

    // two flop synchroniser on the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync1_r <= 1'b1;
            pin_sync2_r <= 1'b1;
        end else begin
            pin_sync1_r <= reset_pin_in;
            pin_sync2_r <= pin_sync1_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_low_r <= 13'h0000;
        end else if (pin_sync2_r) begin
            pin_low_r <= 13'h0000;
        end else if (pin_low_r != 13'h1FFF) begin
            pin_low_r <= pin_low_r + 13'h0001;
        end
    end

    // marks a power-on or low voltage sequence for the longer pin threshold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_lvi_seq_r <= 1'b1;
        end else if (low_voltage_detector) begin
            por_lvi_seq_r <= 1'b1;
        end else if (state_r == ST_RUN) begin
            por_lvi_seq_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // usb single-ended zero detector

    // bus reset after more than 2.5 us of se0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            se0_cnt_r <= 10'h000;
            usb_evt_r <= 1'b0;
        end else if (usb_dp | usb_dm) begin
            se0_cnt_r <= 10'h000;
            usb_evt_r <= 1'b0;
        end else begin
            if (se0_cnt_r != 10'h3FF) begin
                se0_cnt_r <= se0_cnt_r + 10'h001;
            end
            usb_evt_r <= (se0_cnt_r == 10'(`USB_SE0_CYC));
        end
    end

    // usb reset redirected to the external interrupt request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_irq_request <= 1'b0;
        end else begin
            ext_irq_request <= usb_evt_r & ctrl_r[`CTRL_USB_ON] & ~ctrl_r[`CTRL_USB_RST_DIS]
                               & ctrl_r[`CTRL_USB_IRQ_SEL];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog

    // prescaler tick clocks the watchdog; service keeps it short of overflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt_r <= 6'h00;
            wd_ovf_r <= 1'b0;
        end else if (in_reset || svc_r || wd_disable) begin
            wd_cnt_r <= 6'h00;
            wd_ovf_r <= 1'b0;
        end else begin
            wd_ovf_r <= presc_tick && (wd_cnt_r == `WDOG_LAST);
            if (presc_tick) begin
                wd_cnt_r <= wd_cnt_r + 6'h01;
            end
        end
    end

    // overflow passes two flops before it may reset the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_sync1_r <= 1'b0;
            wd_sync2_r <= 1'b0;
        end else begin
            wd_sync1_r <= wd_ovf_r;
            wd_sync2_r <= wd_sync1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            // pin low through the full 4096 count
            ST_POR: begin
                if (!cnt_clr_r && cnt_r == `CNT_FULL) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_DRIVE: begin
                if (!cnt_clr_r && cnt_r == `CNT_DRIVE_END) begin
                    state_nxt = ST_HOLD;
                end
            end
            // 32 more cycles of internal reset after a drive, 64 after power-on
            ST_HOLD: begin
                if (!cnt_clr_r && cnt_r == `CNT_HOLD_END) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_EXT: begin
                if (pin_sync2_r) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_instr && ctrl_r[`CTRL_STOP_EN]) begin
                    state_nxt = ST_STOP;
                end else if (wait_instr) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (wake_event) begin
                    state_nxt = ST_RUN;
                end
            end
            // stop exit waits for the count, running since stop entry, to reach the end value
            ST_STOP: begin
                if (wake_event) begin
                    state_nxt = ST_STOP_REC;
                end
            end
            ST_STOP_REC: begin
                if (!cnt_clr_r && cnt_r == stop_end) begin
                    state_nxt = ST_RUN;
                end
            end
        endcase
        // reset entries override everything; the pin reset leaves the counter alone
        if (lvi_start) begin
            state_nxt = ST_POR;
        end else if (int_rst_evt) begin
            state_nxt = ST_DRIVE;
        end else if (!pin_sync2_r && !in_reset) begin
            state_nxt = ST_EXT;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_POR;
        end else begin
            state_r <= state_nxt;
        end
    end

    // counter clear on internal reset entry and stop entry, never on pin reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_clr_r <= 1'b0;
        end else begin
            cnt_clr_r <= lvi_start | int_rst_evt
                         | (state_r == ST_RUN && state_nxt == ST_STOP);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin, reset and clock outputs

    // pin driven low during power-on count and internal drive window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_pin_oe <= 1'b1;
            internal_reset <= 1'b1;
        end else begin
            reset_pin_oe <= (state_nxt == ST_POR) | (state_nxt == ST_DRIVE);
            // internal reset through every reset state
            internal_reset <= (state_nxt == ST_POR) | (state_nxt == ST_DRIVE)
                              | (state_nxt == ST_HOLD) | (state_nxt == ST_EXT);
        end
    end

    assign reset_pin_out = 1'b0;

    // cpu clock off in wait; peripheral clock kept for modules to decide
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clock_on <= 1'b0;
            periph_clock_on <= 1'b0;
        end else begin
            cpu_clock_on <= (state_nxt == ST_RUN);
            periph_clock_on <= (state_nxt == ST_RUN) | (state_nxt == ST_WAIT);
        end
    end

    // divide by four; held low so a gated clock rests in its inactive phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 2'b00;
            internal_bus_clock <= 1'b0;
        end else if (!periph_clock_on) begin
            // clocks parked in the inactive phase
            div_r <= 2'b00;
            internal_bus_clock <= 1'b0;
        end else begin
            // a quarter of the doubled oscillator input
            div_r <= div_r + 2'b01;
            // follows the divider's next msb, so it toggles every second edge
            internal_bus_clock <= div_r[1] ^ div_r[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_vector <= `VEC_USER;
        end else begin
            reset_vector <= monitor_mode ? `VEC_MONITOR : `VEC_USER;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset cause

    always_comb begin
        new_cause = 8'h00;
        if (lvi_start) begin
            new_cause[`CAUSE_LVI] = 1'b1;
        end else if (wd_sync2_r) begin
            new_cause[`CAUSE_WDOG] = 1'b1;
        end else if (bad_instruction_flag_evt) begin
            new_cause[`CAUSE_BAD_INSTRUCTION_FLAG] = 1'b1;
        end else if (bad_fetch_address_flag_evt) begin
            new_cause[`CAUSE_BAD_FETCH_ADDRESS_FLAG] = 1'b1;
        end else begin
            new_cause[`CAUSE_USB] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // power-on leaves only its own bit
            cause_r <= `CAUSE_POR_VALUE;
        end else begin
            // an internal or low voltage reset replaces the record with its own source
            if (lvi_start || int_rst_evt) begin
                cause_r <= new_cause;
            end else if (!pin_sync2_r && pin_low_r == (por_lvi_seq_r ? `PIN_LOW_AFTER_POR
                                                                     : `PIN_LOW_NORMAL)) begin
                // pin cause once the low time is long enough
                cause_r[`CAUSE_PIN] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, one wait state

    assign apb_wr = psel & penable & pready & pwrite;
    assign apb_rd = psel & penable & ~pready & ~pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & (paddr > `OFS_STATE || paddr[1:0] != 2'b00);
            if (apb_rd) begin
                unique case (paddr)
                    `OFS_CTRL: prdata <= {24'h000000, ctrl_r};
                    `OFS_CAUSE: prdata <= {24'h000000, cause_r};
                    `OFS_STATE: prdata <= {20'h00000, 1'b0, state_r, cnt_r[11:4]};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // any write to the service word restarts the watchdog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            svc_r <= 1'b0;
        end else begin
            svc_r <= apb_wr && paddr == `OFS_WDOG_SVC;
        end
    end

    // usb enable, usb reset disable, pull-up and sticky bits survive all but power-on and low voltage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CTRL_RESET;
        end else if (lvi_start) begin
            ctrl_r <= `CTRL_RESET;
        end else if (int_rst_evt || (!pin_sync2_r && !in_reset)) begin
            ctrl_r[`CTRL_SHORT_STOP] <= 1'b0;
            ctrl_r[`CTRL_STOP_EN] <= 1'b0;
            ctrl_r[`CTRL_USB_IRQ_SEL] <= 1'b0;
        end else if (apb_wr && paddr == `OFS_CTRL) begin
            ctrl_r <= {1'b0, pwdata[6:0]};
        end
    end

    // sticky outputs copied from the control word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_module_on <= 1'b0;
            usb_pullup_on <= 1'b0;
            port_a_bit7_direction <= 1'b0;
        end else begin
            usb_module_on <= ctrl_r[`CTRL_USB_ON];
            usb_pullup_on <= ctrl_r[`CTRL_USB_PULLUP];
            port_a_bit7_direction <= ctrl_r[`CTRL_PA7_DIR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_por_pin_hold: assert property (
        state_r == ST_POR && state_nxt == ST_POR
        |=> reset_pin_oe && !cpu_clock_on && !internal_bus_clock)
        else $error("pin or clocks active during power-on count");
    chk_drive_to_hold: assert property (
        state_r == ST_DRIVE && !cnt_clr_r && cnt_r == `CNT_DRIVE_END
        |=> state_r == ST_HOLD ##1 !reset_pin_oe && internal_reset)
        else $error("drive window not 32 cycles");
    chk_hold_release: assert property (
        state_r == ST_HOLD && !cnt_clr_r && cnt_r == `CNT_HOLD_END |=> !internal_reset)
        else $error("internal reset not released after hold");
    chk_wait_clocks: assert property (
        state_r == ST_WAIT && $past(state_r) == ST_WAIT |-> !cpu_clock_on && periph_clock_on)
        else $error("wait mode clocks wrong");
    chk_stop_recovery: assert property (
        state_r == ST_STOP_REC && !cnt_clr_r && cnt_r == stop_end && !lvi_start
        && !int_rst_evt && pin_sync2_r |=> state_r == ST_RUN)
        else $error("stop recovery length wrong");
    chk_wdog_cause: assert property (
        wd_ovf_r && !in_reset && !low_voltage_detector ##2 !in_reset && !low_voltage_detector
        |=> cause_r[`CAUSE_WDOG] && state_r == ST_DRIVE)
        else $error("watchdog overflow not recorded");
    chk_usb_gate: assert property (
        !ctrl_r[`CTRL_USB_ON] |-> !usb_rst_evt ##1 !ext_irq_request)
        else $error("usb reset while usb disabled");
    chk_data_fetch: assert property (
        state_r == ST_RUN && unmapped_access && !opcode_fetch && !bad_opcode && !stop_instr
        && !wd_sync2_r && !usb_rst_evt && !low_voltage_detector && pin_sync2_r
        |=> state_r != ST_DRIVE)
        else $error("data fetch caused a reset");
    chk_bus_quarter: assert property (
        periph_clock_on && $past(periph_clock_on, 2)
        |-> internal_bus_clock != $past(internal_bus_clock, 2))
        else $error("bus clock not a quarter rate");
    chk_pin_no_clear: assert property (
        state_r != ST_EXT && state_nxt == ST_EXT |=> !cnt_clr_r)
        else $error("pin reset cleared the counter");

endmodule : system_clock_reset_sequencer

// file: logic/clk_rst_seq_cfg.svh
// offsets, field positions, reset values and timing counts of the clock and reset sequencer
`ifndef CLK_RST_SEQ_CFG_SVH
`define CLK_RST_SEQ_CFG_SVH

// apb register byte offsets
`define OFS_CTRL 12'h000
`define OFS_CAUSE 12'h004
`define OFS_WDOG_SVC 12'h008
`define OFS_STATE 12'h00C

// control register fields
`define CTRL_SHORT_STOP 0
`define CTRL_STOP_EN 1
`define CTRL_USB_IRQ_SEL 2
`define CTRL_USB_RST_DIS 3
`define CTRL_USB_ON 4
`define CTRL_USB_PULLUP 5
`define CTRL_PA7_DIR 6
`define CTRL_RESET 8'h00

// reset cause fields
`define CAUSE_POR 7
`define CAUSE_PIN 6
`define CAUSE_WDOG 5
`define CAUSE_BAD_INSTRUCTION_FLAG 4
`define CAUSE_BAD_FETCH_ADDRESS_FLAG 3
`define CAUSE_USB 2
`define CAUSE_LVI 1
`define CAUSE_POR_VALUE 8'h80

// stabilisation counter end values (count of doubled oscillator cycles minus one) and the service mask
`define CNT_FULL 12'hFFF
`define CNT_HALF 12'h7FF
`define CNT_DRIVE_END 12'h01F
`define CNT_HOLD_END 12'h03F
`define CNT_SVC_MASK 12'h00F

// pin low times needed for the pin cause bit
`define PIN_LOW_NORMAL 13'h0043
`define PIN_LOW_AFTER_POR 13'h1043

// usb single-ended zero time, least time so it rounds up
`define CLK_PERIOD_NS 4
`define USB_SE0_TIME_NS 2500
`define USB_SE0_CYC ((`USB_SE0_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// watchdog length in prescaler ticks, and reset vectors
`define WDOG_LAST 6'h3F
`define VEC_USER 16'hFFFE
`define VEC_MONITOR 16'hFEFE
`endif

// file: logic/clk_rst_seq_pkg.sv
// types of the clock and reset sequencer
package clk_rst_seq_pkg;
    typedef enum logic [2:0] {
        ST_POR      = 3'b000,
        ST_DRIVE    = 3'b001,
        ST_HOLD     = 3'b010,
        ST_EXT      = 3'b011,
        ST_RUN      = 3'b100,
        ST_WAIT     = 3'b101,
        ST_STOP     = 3'b110,
        ST_STOP_REC = 3'b111
    } seq_e;
endpackage : clk_rst_seq_pkg

// file: testbench/reset_pin_partner.sv
// reset pin wire with pull-up, device driver and an outside party
`timescale 1ns/10ps
module reset_pin_partner (
    input wire logic reset_pin_oe,
    input wire logic reset_pin_out,
    input wire logic pull_low,
    output logic pin_w
);
    // outside party holds pin low
    // wired-and: a released pin floats back up through the pull-up
    assign pin_w = !(reset_pin_oe && !reset_pin_out) && !pull_low;
endmodule : reset_pin_partner

// file: testbench/tb_system_clock_reset_sequencer.sv
// self-checking bench for the clock and reset sequencer
`timescale 1ns/10ps
`include "clk_rst_seq_cfg.svh"
module tb_system_clock_reset_sequencer;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin_w, pull_low = 0;
    logic bad_opcode = 0, stop_instr = 0, lv = 0, fetch = 0, mon = 0, idle = 0, usb = 1;
    logic opc = 1, wk = 0, cpu_on, per_on, uon;
    logic pready, pslverr, reset_pin_out, reset_pin_oe, internal_reset, internal_bus_clock, b, err;
    logic [11:0] paddr = 12'h000;
    logic [15:0] vec;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int bad_count = 0, n_compared = 0, n;
    ////////////////////////////////////////////////////////////////////////
    always #2 pclk = ~pclk;
    reset_pin_partner i_reset_pin_partner (.reset_pin_oe, .reset_pin_out, .pull_low, .pin_w);
    system_clock_reset_sequencer i_system_clock_reset_sequencer (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pin_in(pin_w),
        .reset_pin_out, .reset_pin_oe, .low_voltage_detector(lv), .bad_opcode, .stop_instr,
        .wait_instr(idle), .wake_event(wk), .unmapped_access(fetch), .opcode_fetch(opc),
        .usb_dp(usb), .usb_dm(usb), .monitor_mode(mon), .break_state(1'b0),
        .reset_pin_test_high_voltage(1'b0), .irq_pin_test_high_voltage(1'b0), .internal_reset,
        .cpu_clock_on(cpu_on), .periph_clock_on(per_on), .internal_bus_clock, .reset_vector(vec),
        .ext_irq_request(), .usb_module_on(uon), .usb_pullup_on(), .port_a_bit7_direction());
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one apb transfer; waits for pready (only the watchdog ends a dead wait), then one idle edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb
    // cycles a level stays high; the cap keeps a stuck output from hanging
    task automatic hi_len(input bit which, output int c);
        c = 0;
        while ((which ? internal_reset : reset_pin_oe) === 1'h1 && c < 5000) begin
            @(posedge pclk);
            c++;
        end
    endtask : hi_len
    // drive and hold phases of a reset, then the cause byte
    task automatic seq_rst(input int drive, input int hold, input logic [31:0] cause);
        @(posedge pclk);
        bad_opcode <= 1'h0;
        stop_instr <= 1'h0;
        fetch <= 1'h0;
        lv <= 1'h0;
        // the reset is launched at the edge above; its registered outputs change at that same edge
        @(posedge pclk);
        hi_len(0, n);
        chk(32'(n > drive - 3 && n < drive + 2), 32'h1);
        hi_len(1, n);
        chk(32'(n > hold - 3 && n < hold + 3), 32'h1);
        apb(1'h0, `OFS_CAUSE, 32'h0);
        chk(rd, cause);
    endtask : seq_rst
    task automatic tally_and_finish;
        $display("compared %0d, wrong %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        bad_count++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        seq_rst(4096, 64, 32'h80);
        chk(vec, 32'hFFFE);
        apb(1'h0, 12'h010, 32'h0);
        chk(err, 1'h1);
        // bus clock flips every second pclk edge
        @(posedge pclk);
        b = internal_bus_clock;
        repeat (2) @(posedge pclk);
        chk(internal_bus_clock, !b);
        // wait stops only the cpu clock; a wake event brings it back
        idle <= 1'h1;
        @(posedge pclk);
        idle <= 1'h0;
        repeat (2) @(posedge pclk);
        chk(cpu_on, 1'h0);
        chk(per_on, 1'h1);
        wk <= 1'h1;
        @(posedge pclk);
        wk <= 1'h0;
        repeat (2) @(posedge pclk);
        chk(cpu_on, 1'h1);
        // a service write leaves only the low four counter stages
        apb(1'h1, `OFS_WDOG_SVC, 32'h0);
        apb(1'h0, `OFS_STATE, 32'h0);
        chk(32'(rd[7:0] < 8'h02), 32'h1);
        bad_opcode <= 1'h1;
        seq_rst(32, 32, 32'h10);
        stop_instr <= 1'h1;
        seq_rst(32, 32, 32'h10);
        fetch <= 1'h1;
        seq_rst(32, 32, 32'h08);
        // a data fetch from unmapped space must not reset
        opc <= 1'h0;
        fetch <= 1'h1;
        repeat (3) @(posedge pclk);
        chk(internal_reset, 1'h0);
        fetch <= 1'h0;
        opc <= 1'h1;
        // usb on, then a held single-ended zero; the usb enable survives the reset
        apb(1'h1, `OFS_CTRL, 32'h10);
        usb <= 1'h0;
        repeat (`USB_SE0_CYC + 1) @(posedge pclk);
        seq_rst(32, 32, 32'h04);
        usb <= 1'h1;
        chk(uon, 1'h1);
        lv <= 1'h1;
        seq_rst(4096, 64, 32'h02);
        chk(uon, 1'h0);
        pull_low <= 1'h1;
        repeat (100) @(posedge pclk);
        pull_low <= 1'h0;
        repeat (10) @(posedge pclk);
        apb(1'h0, `OFS_CAUSE, 32'h0);
        chk(rd, 32'h42);
        mon <= 1'h1;
        repeat (3) @(posedge pclk);
        chk(vec, 16'hFEFE);
        tally_and_finish;
    end
endmodule : tb_system_clock_reset_sequencer
